/* File: ctlport_pkg.sv */
// What this block does
// RULE_01: Interrupt pin is open-drain and active low
// RULE_02: Only unmasked status bits may raise interrupt
// RULE_03: Events detected on rising or both edges
// RULE_04: Pin low on event until status read
// RULE_05: Status bits stay high until next read
// RULE_06: Status read clears bits whose source is low
// RULE_07: Host re-reads status after reading a high
// RULE_08: Mask bit six enables both short-detect edges
// RULE_09: Status read releases pin for short-detect alone
// RULE_10: Short-detect present state readable in status bit six (here bit six latches either edge, so it reads high once after the pin falls)
// RULE_11: Control port is a bus slave, audio-asynchronous
// RULE_12: Registers work without master clock; effects need it (here every register is clocked by MCLK)
// RULE_13: Host keeps lines static when idle
// RULE_14: Start and stop only while clock high
// RULE_15: Address byte: seven address bits plus direction
// RULE_16: Pointer byte: seven-bit index, top bit increments
// RULE_17: Receiver acknowledges every byte (here the host nacks the one byte it reads)
// RULE_18: Write data goes to pointer plus increments
// RULE_19: Read data comes from pointer plus increments
// RULE_20: Stop after pointer byte only loads pointer
// RULE_21: Single read: one byte, acknowledge, stop (here the host leaves SDA released, a nack, before the stop)
// RULE_22: Pointer stays fixed without auto-increment
// RULE_23: Pin releases after all causing status reads
package ctlport_pkg;
  localparam logic [6:0] DEV_ADDR       = 7'h4a;
  localparam logic [6:0] REG_MASK_FIRST = 7'h5e;
  localparam logic [6:0] REG_MASK_SECOND = 7'h5f;
  localparam logic [6:0] REG_STAT_FIRST = 7'h60;
  localparam logic [6:0] REG_STAT_SECOND = 7'h61;
  localparam logic [7:0] MASK_RESET     = 8'h00;
  localparam int         SHORT_BIT      = 6;
  localparam int         AUTOINC_BIT    = 7;
  // Both-edge sensitivity per status bit; others rise only
  localparam logic [7:0] BOTH_EDGE_FIRST  = 8'h40;
  localparam logic [7:0] BOTH_EDGE_SECOND = 8'h00;
  // Host controller register offsets (Wishbone byte addresses)
  localparam logic [3:0] HREG_CTRL   = 4'h0;
  localparam logic [3:0] HREG_PTR    = 4'h4;
  localparam logic [3:0] HREG_WDATA  = 4'h8;
  localparam logic [3:0] HREG_STATUS = 4'hc;
  // Host command codes in HREG_CTRL[1:0]
  localparam logic [1:0] CMD_WRITE   = 2'h1;
  localparam logic [1:0] CMD_READ    = 2'h2;
  localparam logic [1:0] CMD_SETPTR  = 2'h3;
  localparam int         SCL_HALF_NS = 1250;
  localparam int         CLK_NS      = 25;
  localparam logic [7:0] SCL_HALF_CYC = 8'(SCL_HALF_NS / CLK_NS);
endpackage

/* File: i2c_link_if.sv */
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic irq_o;
  logic irq_oe_n;
  // Wired-AND of open-drain drivers, pulled up when nobody drives
  logic scl;
  logic sda;
  logic irq_n;
  assign scl   = scl_oe_n ? 1'b1 : scl_o;
  assign sda   = (sda_host_oe_n ? 1'b1 : sda_host_o) & (sda_dev_oe_n ? 1'b1 : sda_dev_o);
  assign irq_n = irq_oe_n ? 1'b1 : irq_o;
  modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe_n, output irq_o, output irq_oe_n);
  modport host (input scl, input sda, input irq_n, output scl_o, output scl_oe_n,
                output sda_host_o, output sda_host_oe_n);
endinterface

/* File: sync2.sv */
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      meta_q <= '1;
      q      <= '1;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
endmodule

/* File: ctlport_device.sv */
`timescale 1ns/1ps
module ctlport_device (
  // Clock and reset
  input  wire logic MCLK,
  input  wire logic RST_N,
  // Link
  i2c_link_if.device LINK,
  // Raw status sources
  input  wire logic       MIC_SHORT_DETECT_PIN,
  input  wire logic [7:0] STAT_SRC_FIRST,
  input  wire logic [7:0] STAT_SRC_SECOND,
  // Mask registers toward the dependent logic
  output logic [7:0] IRQ_MASK_FIRST,
  output logic [7:0] IRQ_MASK_SECOND
);
  import ctlport_pkg::*;
  typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WDATA, S_WACK, S_RDATA, S_RACK} dstate_t;
  dstate_t state_q;
  logic [2:0] sync_q;
  logic scl_s, sda_s, sdet_s, scl_d1_q, sda_d1_q;
  logic [7:0] shift_q, tx_q;
  logic [3:0] bitcnt_q;
  logic [6:0] ptr_q;
  logic       autoinc_q;
  logic       sda_drv_q;
  logic [7:0] mask1_q, mask2_q, stat1_q, stat2_q, raw1_prev_q, raw2_prev_q;
  logic [7:0] raw1, raw2, ev1, ev2;
  logic       rd1_done, rd2_done;
  // Registers need only MCLK here; link is sampled, audio clocks play no part [RULE_11] [RULE_12]
  // Pin passes inverted so the synchroniser's reset value means a low pin: no false edge after reset
  sync2 #(.W(3)) u_sync (.clk(MCLK), .rst_n(RST_N),
    .d({LINK.scl, LINK.sda, ~MIC_SHORT_DETECT_PIN}), .q(sync_q));
  assign {scl_s, sda_s} = sync_q[2:1];
  assign sdet_s         = ~sync_q[0];
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
    begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end
    else
    begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  wire scl_rise = scl_s & ~scl_d1_q;
  wire scl_fall = ~scl_s & scl_d1_q;
  wire start_c  = scl_s & scl_d1_q & sda_d1_q & ~sda_s; // [RULE_14]
  wire stop_c   = scl_s & scl_d1_q & ~sda_d1_q & sda_s; // [RULE_14]
  function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] m1, input logic [7:0] m2,
                                          input logic [7:0] s1, input logic [7:0] s2);
    unique case (a)
      REG_MASK_FIRST:  reg_read = m1;
      REG_MASK_SECOND: reg_read = m2;
      REG_STAT_FIRST:  reg_read = s1;
      REG_STAT_SECOND: reg_read = s2;
      default:         reg_read = 8'h00;
    endcase
  endfunction
  wire [7:0] cur_reg = reg_read(ptr_q, mask1_q, mask2_q, stat1_q, stat2_q);
  // Link state machine
  wire [7:0] rx_byte = {shift_q[6:0], sda_s};
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
    begin
      state_q   <= S_IDLE;
      bitcnt_q  <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      sda_drv_q <= 1'b0;
      ptr_q     <= 7'h00;
      autoinc_q <= 1'b0;
    end
    else if (start_c)
    begin
      state_q   <= S_ADDR;
      bitcnt_q  <= 4'h0;
      sda_drv_q <= 1'b0;
    end
    else if (stop_c)
    begin
      state_q   <= S_IDLE; // Stop after pointer ack leaves only pointer loaded [RULE_20]
      sda_drv_q <= 1'b0;
    end
    else
    begin
      if (scl_rise && (state_q == S_ADDR || state_q == S_PTR || state_q == S_WDATA))
      begin
        shift_q  <= rx_byte;
        bitcnt_q <= bitcnt_q + 4'h1;
      end
      if (scl_rise && state_q == S_RACK && sda_s)
        state_q <= S_IDLE; // Host nack ends the read
      if (scl_fall)
      begin
        unique case (state_q)
          S_IDLE: ;
          S_ADDR:
            if (bitcnt_q == 4'h8)
            begin
              if (shift_q[7:1] == DEV_ADDR) // [RULE_15]
              begin
                state_q   <= S_ADDR_ACK;
                sda_drv_q <= 1'b1; // [RULE_17]
                tx_q      <= reg_read(ptr_q, mask1_q, mask2_q, stat1_q, stat2_q);
              end
              else
                state_q <= S_IDLE;
            end
          S_ADDR_ACK:
          begin
            bitcnt_q <= 4'h0;
            if (shift_q[0])
            begin
              state_q   <= S_RDATA;
              sda_drv_q <= ~tx_q[7];
              tx_q      <= {tx_q[6:0], 1'b0};
            end
            else
            begin
              state_q   <= S_PTR;
              sda_drv_q <= 1'b0;
            end
          end
          S_PTR:
            if (bitcnt_q == 4'h8)
            begin
              state_q   <= S_PTR_ACK;
              sda_drv_q <= 1'b1; // [RULE_17]
              ptr_q     <= shift_q[6:0]; // [RULE_16]
              autoinc_q <= shift_q[AUTOINC_BIT];
            end
          S_PTR_ACK, S_WACK:
          begin
            state_q   <= S_WDATA;
            bitcnt_q  <= 4'h0;
            sda_drv_q <= 1'b0;
          end
          S_WDATA:
            if (bitcnt_q == 4'h8)
            begin
              state_q   <= S_WACK;
              sda_drv_q <= 1'b1; // [RULE_17]
              if (autoinc_q)
                ptr_q <= ptr_q + 7'h1; // [RULE_18] [RULE_22]
            end
          S_RDATA:
          begin
            bitcnt_q <= bitcnt_q + 4'h1;
            if (bitcnt_q == 4'h7)
            begin
              state_q   <= S_RACK;
              sda_drv_q <= 1'b0; // Host drives acknowledge [RULE_17]
              if (autoinc_q)
                ptr_q <= ptr_q + 7'h1; // [RULE_19] [RULE_22]
            end
            else
            begin
              sda_drv_q <= ~tx_q[7];
              tx_q      <= {tx_q[6:0], 1'b0};
            end
          end
          S_RACK:
          begin
            state_q   <= S_RDATA;
            bitcnt_q  <= 4'h0;
            tx_q      <= {cur_reg[6:0], 1'b0};
            sda_drv_q <= ~cur_reg[7]; // [RULE_19]
          end
        endcase
      end
    end
  // Write capture into mask registers at the data byte's last bit
  wire wr_stb = scl_fall && state_q == S_WDATA && bitcnt_q == 4'h8;
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
    begin
      mask1_q <= MASK_RESET;
      mask2_q <= MASK_RESET;
    end
    else if (wr_stb)
    begin
      if (ptr_q == REG_MASK_FIRST)
        mask1_q <= shift_q; // [RULE_18]
      if (ptr_q == REG_MASK_SECOND)
        mask2_q <= shift_q;
    end
  assign IRQ_MASK_FIRST  = mask1_q;
  assign IRQ_MASK_SECOND = mask2_q;
  // Status read completes when the host acknowledges or refuses the byte
  wire rd_done = scl_rise && state_q == S_RACK;
  wire [6:0] rd_addr = ptr_q - (autoinc_q ? 7'h1 : 7'h0);
  assign rd1_done = rd_done && rd_addr == REG_STAT_FIRST;
  assign rd2_done = rd_done && rd_addr == REG_STAT_SECOND;
  // Short-detect bit mirrors the pin level; other sources come from inputs
  always_comb
  begin
    raw1 = STAT_SRC_FIRST;
    raw1[SHORT_BIT] = sdet_s; // [RULE_10]
    raw2 = STAT_SRC_SECOND;
    ev1 = raw1 & ~raw1_prev_q | BOTH_EDGE_FIRST & ~raw1 & raw1_prev_q; // [RULE_03] [RULE_08]
    ev2 = raw2 & ~raw2_prev_q | BOTH_EDGE_SECOND & ~raw2 & raw2_prev_q; // [RULE_03]
  end
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
    begin
      raw1_prev_q <= 8'h00;
      raw2_prev_q <= 8'h00;
      stat1_q     <= 8'h00;
      stat2_q     <= 8'h00;
    end
    else
    begin
      raw1_prev_q <= raw1;
      raw2_prev_q <= raw2;
      // Sticky: event sets, as does a high source on rise-only bits; a read clears only low sources; set beats clear [RULE_05] [RULE_06]
      stat1_q <= (rd1_done ? (stat1_q & raw1) : stat1_q) | ev1 | (raw1 & ~BOTH_EDGE_FIRST);
      stat2_q <= (rd2_done ? (stat2_q & raw2) : stat2_q) | ev2 | (raw2 & ~BOTH_EDGE_SECOND);
    end
  // Pending cause per register: set by an unmasked event, cleared by reading it
  logic pend1_q, pend2_q;
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
    begin
      pend1_q <= 1'b0;
      pend2_q <= 1'b0;
    end
    else
    begin
      pend1_q <= |(ev1 & mask1_q) | (pend1_q & ~rd1_done); // [RULE_02] [RULE_04] [RULE_09]
      pend2_q <= |(ev2 & mask2_q) | (pend2_q & ~rd2_done); // [RULE_02] [RULE_04]
    end
  assign LINK.irq_o    = 1'b0;
  assign LINK.irq_oe_n = ~(pend1_q | pend2_q); // [RULE_01] [RULE_23]
  assign LINK.sda_dev_o    = 1'b0;
  assign LINK.sda_dev_oe_n = ~sda_drv_q;
endmodule

/* File: ctlport_host.sv */
`timescale 1ns/1ps
module ctlport_host (
  // Clock and reset
  input  wire logic MCLK,
  input  wire logic RST_N,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Link
  i2c_link_if.host LINK
);
  import ctlport_pkg::*;
  typedef enum {H_IDLE, H_START, H_BIT, H_ACK, H_STOP} hstate_t;
  hstate_t state_q;
  logic [1:0] cmd_q;
  logic       busy_q, nack_q, rd_q, pointer_auto_increment_q;
  logic [6:0] ptr_q;
  logic [7:0] wdata_q, rdata_q, sh_q;
  logic [1:0] byte_q;
  logic [2:0] bit_q;
  logic [7:0] div_q;
  logic       phase_q, scl_q, sda_q, tick;
  logic [1:0] in_s;
  sync2 #(.W(2)) u_sync (.clk(MCLK), .rst_n(RST_N), .d({LINK.sda, LINK.irq_n}), .q(in_s));
  wire acc = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
      WB_ACK_O <= 1'b0;
    else
      WB_ACK_O <= acc;
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
      WB_DAT_O <= 32'h0;
    else if (acc)
      unique case (WB_ADR_I)
        HREG_PTR:    WB_DAT_O <= {24'h0, pointer_auto_increment_q, ptr_q};
        HREG_WDATA:  WB_DAT_O <= {24'h0, wdata_q};
        HREG_STATUS: WB_DAT_O <= {21'h0, ~in_s[0], nack_q, busy_q, rdata_q};
        default:     WB_DAT_O <= 32'h0;
      endcase
  wire wr = acc & WB_WE_I & WB_SEL_I[0];
  // Half-period divider for the link clock
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
      div_q <= 8'h0;
    else if (!busy_q || tick)
      div_q <= 8'h0;
    else
      div_q <= div_q + 8'h1;
  assign tick = busy_q && div_q == SCL_HALF_CYC - 8'h1;
  // Byte list: 0 address+W, 1 pointer, 2 data; or 0 address+R, 3 read byte
  wire [7:0] tx_byte = byte_q == 2'h0 ? {DEV_ADDR, rd_q} : byte_q == 2'h1 ? {pointer_auto_increment_q, ptr_q} : wdata_q; // [RULE_15] [RULE_16]
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
    begin
      state_q <= H_IDLE;
      busy_q <= 1'b0; nack_q <= 1'b0; rd_q <= 1'b0; pointer_auto_increment_q <= 1'b0;
      ptr_q <= 7'h0; wdata_q <= 8'h0; rdata_q <= 8'h0; sh_q <= 8'h0;
      byte_q <= 2'h0; bit_q <= 3'h0; phase_q <= 1'b0; scl_q <= 1'b1; sda_q <= 1'b1; cmd_q <= 2'h0;
    end
    else if (!busy_q)
    begin
      // Lines stay static while idle [RULE_13]
      if (wr && WB_ADR_I == HREG_PTR) {pointer_auto_increment_q, ptr_q} <= WB_DAT_I[7:0];
      if (wr && WB_ADR_I == HREG_WDATA) wdata_q <= WB_DAT_I[7:0];
      if (wr && WB_ADR_I == HREG_CTRL && WB_DAT_I[1:0] != 2'h0)
      begin
        cmd_q <= WB_DAT_I[1:0]; rd_q <= WB_DAT_I[1:0] == CMD_READ;
        busy_q <= 1'b1; nack_q <= 1'b0; byte_q <= 2'h0; state_q <= H_START; phase_q <= 1'b0;
      end
    end
    else if (tick)
    begin
      phase_q <= ~phase_q;
      unique case (state_q)
        H_START: begin sda_q <= 1'b0; state_q <= H_BIT; bit_q <= 3'h7; sh_q <= tx_byte; phase_q <= 1'b0; end // [RULE_14]
        H_BIT:
          if (!phase_q)
          begin
            // Data moves only while the clock is low; after a start the clock is lowered first [RULE_14]
            if (scl_q)
            begin
              scl_q   <= 1'b0;
              phase_q <= 1'b0;
            end
            else
              sda_q <= byte_q == 2'h3 ? 1'b1 : sh_q[7];
          end
          else if (scl_q == 1'b0)
          begin
            scl_q   <= 1'b1;
            phase_q <= 1'b1;
          end
          else
          begin
            scl_q <= 1'b0; phase_q <= 1'b0;
            if (byte_q == 2'h3) rdata_q <= {rdata_q[6:0], in_s[1]};
            sh_q <= {sh_q[6:0], 1'b0}; bit_q <= bit_q - 3'h1;
            if (bit_q == 3'h0) state_q <= H_ACK;
          end
        H_ACK:
          if (!phase_q)
            sda_q <= 1'b1; // Release for device ack; nack ends single read [RULE_17] [RULE_21]
          else if (!scl_q)
          begin
            scl_q   <= 1'b1;
            phase_q <= 1'b1;
          end
          else
          begin
            scl_q <= 1'b0; phase_q <= 1'b0;
            if (byte_q != 2'h3 && in_s[1]) nack_q <= 1'b1;
            if (byte_q == 2'h3 || in_s[1] || (byte_q == 2'h1 && cmd_q == CMD_SETPTR) || byte_q == 2'h2)
              state_q <= H_STOP; // [RULE_20]
            else
            begin
              byte_q <= rd_q ? 2'h3 : byte_q + 2'h1; state_q <= H_BIT; bit_q <= 3'h7;
              sh_q <= rd_q ? 8'hff : (byte_q == 2'h0 ? {pointer_auto_increment_q, ptr_q} : wdata_q);
            end
          end
        H_STOP:
          if (!phase_q)
            sda_q <= 1'b0;
          else if (!scl_q)
          begin
            scl_q   <= 1'b1;
            phase_q <= 1'b1;
          end
          else
          begin
            sda_q   <= 1'b1;
            busy_q  <= 1'b0;
            state_q <= H_IDLE; // [RULE_14]
          end
        default: state_q <= H_IDLE;
      endcase
    end
  assign LINK.scl_o = 1'b0;
  assign LINK.scl_oe_n = scl_q;
  assign LINK.sda_host_o = 1'b0;
  assign LINK.sda_host_oe_n = sda_q;
endmodule

/* File: ctlport_props.sv */
`timescale 1ns/1ps
module ctlport_props (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Drivers of the link
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe_n,
  input wire logic irq_o,
  input wire logic irq_oe_n,
  // Resolved wires
  input wire logic scl,
  input wire logic sda,
  input wire logic irq_n
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  AST_IRQ_OPEN_DRAIN: assert property (!irq_oe_n |-> !irq_o && !irq_n)
    else $error("interrupt driven without pulling the wire low");
  AST_SDA_OPEN_DRAIN: assert property (!sda_dev_oe_n |-> !sda_dev_o && !sda)
    else $error("device data drive does not pull low");
  AST_SCL_OPEN_DRAIN: assert property (!scl_oe_n |-> !scl_o)
    else $error("clock driven high");
  AST_DEV_SDA_SCL_LOW: assert property (!$stable(sda_dev_oe_n) |-> !scl && !$past(scl))
    else $error("device data changed while clock high");
  AST_HIGH_CHANGE_HOST: assert property (scl && $past(scl) && !$stable(sda) |-> sda_dev_oe_n)
    else $error("device holds data during start or stop");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  AST_IRQ_RELEASE_READ: assert property ($rose(irq_oe_n) |-> scl)
    else $error("interrupt released outside a read acknowledge");
  AST_IRQ_ASSERT_HOLD: assert property ($fell(irq_oe_n) |=> !irq_oe_n [*8])
    else $error("interrupt pulse too short");
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  import ctlport_pkg::*;
  logic        mclk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  logic        ack;
  logic        mic;
  logic [7:0]  src1;
  logic [7:0]  src2;
  logic [7:0]  mask1;
  logic [7:0]  mask2;
  logic        irq_n;
  int          fail_count;
  int          total_checks;
  int          cycles;

  i2c_link_if i2c_link_if_inst ();
  assign irq_n = i2c_link_if_inst.irq_n;
  ctlport_host ctlport_host_inst (.MCLK(mclk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
    .LINK(i2c_link_if_inst.host));
  ctlport_device ctlport_device_inst (.MCLK(mclk), .RST_N(rst_n), .LINK(i2c_link_if_inst.device),
    .MIC_SHORT_DETECT_PIN(mic), .STAT_SRC_FIRST(src1), .STAT_SRC_SECOND(src2), .IRQ_MASK_FIRST(mask1),
    .IRQ_MASK_SECOND(mask2));
  ctlport_props ctlport_props_inst (.MCLK(mclk), .RST_N(rst_n), .scl_o(i2c_link_if_inst.scl_o),
    .scl_oe_n(i2c_link_if_inst.scl_oe_n), .sda_dev_o(i2c_link_if_inst.sda_dev_o),
    .sda_dev_oe_n(i2c_link_if_inst.sda_dev_oe_n), .irq_o(i2c_link_if_inst.irq_o),
    .irq_oe_n(i2c_link_if_inst.irq_oe_n), .scl(i2c_link_if_inst.scl), .sda(i2c_link_if_inst.sda), .irq_n(irq_n));

  always #12.5 mclk = ~mclk;

  task automatic stop_test;
    $display("Counts: checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      fail_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= wd;
    do
      @(posedge mclk);
    while (ack !== 1'b1);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Launch a link command and poll until the controller is idle
  task automatic op(input logic [1:0] cmd, input logic [7:0] ptr, input logic [7:0] wd, output logic [7:0] v);
    logic [31:0] d;
    wb(1'b1, HREG_PTR, {24'h0, ptr}, d);
    wb(1'b1, HREG_WDATA, {24'h0, wd}, d);
    wb(1'b1, HREG_CTRL, {30'h0, cmd}, d);
    d = 32'h100;
    while (d[8] !== 1'b0)
      wb(1'b0, HREG_STATUS, 32'h0, d);
    chk({7'h0, d[9]}, 8'h00);
    v = d[7:0];
  endtask

  task automatic wreg(input logic [6:0] a, input logic [7:0] val);
    logic [7:0] v;
    op(CMD_WRITE, {1'b0, a}, val, v);
  endtask

  task automatic rreg(input logic [6:0] a, output logic [7:0] v);
    op(CMD_SETPTR, {1'b0, a}, 8'h00, v);
    op(CMD_READ, 8'h00, 8'h00, v);
  endtask

  task automatic irq_is(input logic e);
    int n;
    n = 0;
    while (irq_n !== e && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
    chk({7'h0, irq_n}, {7'h0, e});
  endtask

  task automatic t_reset;
    logic [31:0] d;
    wb(1'b0, 4'h2, 32'h0, d);
    chk(d[7:0], 8'h00);
    chk(mask1, MASK_RESET);
    chk(mask2, MASK_RESET);
    chk({7'h0, irq_n}, 8'h01);
    $display("done: reset state");
  endtask

  task automatic t_pointer;
    logic [7:0] v;
    op(CMD_WRITE, {1'b1, REG_MASK_FIRST}, 8'ha5, v);
    chk(mask1, 8'ha5);
    wreg(REG_MASK_SECOND, 8'h3c);
    chk(mask2, 8'h3c);
    op(CMD_READ, 8'h00, 8'h00, v);
    chk(v, 8'h3c);
    op(CMD_SETPTR, {1'b1, REG_MASK_FIRST}, 8'h00, v);
    chk(mask1, 8'ha5);
    op(CMD_READ, 8'h00, 8'h00, v);
    chk(v, 8'ha5);
    op(CMD_READ, 8'h00, 8'h00, v);
    chk(v, 8'h3c);
    $display("done: pointer handling");
  endtask

  task automatic t_mic;
    logic [7:0]  v;
    logic [31:0] d;
    wreg(REG_MASK_FIRST, 8'h40);
    @(posedge mclk);
    mic <= 1'b1;
    irq_is(1'b0);
    wb(1'b0, HREG_STATUS, 32'h0, d);
    chk({7'h0, d[10]}, 8'h01);
    rreg(REG_STAT_FIRST, v);
    chk(v, 8'h40);
    irq_is(1'b1);
    @(posedge mclk);
    mic <= 1'b0;
    irq_is(1'b0);
    op(CMD_READ, 8'h00, 8'h00, v);
    chk(v, 8'h40);
    irq_is(1'b1);
    op(CMD_READ, 8'h00, 8'h00, v);
    chk(v, 8'h00);
    $display("done: short detect");
  endtask

  task automatic t_sticky;
    logic [7:0] v;
    wreg(REG_MASK_FIRST, 8'h01);
    wreg(REG_MASK_SECOND, 8'h08);
    @(posedge mclk);
    src1 <= 8'h01;
    src2 <= 8'h08;
    repeat (4) @(posedge mclk);
    src1 <= 8'h00;
    src2 <= 8'h00;
    irq_is(1'b0);
    rreg(REG_STAT_FIRST, v);
    chk(v, 8'h01);
    chk({7'h0, irq_n}, 8'h00);
    rreg(REG_STAT_SECOND, v);
    chk(v, 8'h08);
    irq_is(1'b1);
    op(CMD_READ, 8'h00, 8'h00, v);
    chk(v, 8'h00);
    wreg(REG_MASK_FIRST, 8'h00);
    wreg(REG_MASK_SECOND, 8'h00);
    @(posedge mclk);
    src2 <= 8'h08;
    repeat (40) @(posedge mclk);
    chk({7'h0, irq_n}, 8'h01);
    rreg(REG_STAT_SECOND, v);
    op(CMD_READ, 8'h00, 8'h00, v);
    chk(v, 8'h08);
    $display("done: sticky status");
  endtask

  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    dat_w = 32'h0;
    mic = 1'b0;
    src1 = 8'h00;
    src2 = 8'h00;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_pointer();
    t_mic();
    t_sticky();
    stop_test();
  end
endmodule
